// ==== pkg/vcs_defs.svh ====
// Constants shared by both ends of the voice channel setup link.
// Assumes inclusion by bare name from any file that needs the numbers.
`ifndef VCS_DEFS_SVH
`define VCS_DEFS_SVH

// Channel counts and staging depth
`define VCS_NCH 8
`define VCS_DIRECT_CHANS 4
`define VCS_DIRECT_BYTES 3'h7
`define VCS_SEL_OPERANDS 3'h2

// Command opcodes, carried in data bits 7..4 of a command byte
`define VCS_OP_SILENCE 4'h1
`define VCS_OP_PHRASE 4'h2
`define VCS_OP_DIRECT 4'h3

// Silence step 4.096 ms, kept in microseconds, and the clock rate
`define VCS_SIL_STEP_US 4096
`define VCS_CLK_MHZ 20
`define VCS_SIL_STEP_CYC (`VCS_SIL_STEP_US * `VCS_CLK_MHZ)

// Host pin strobe width in clock cycles
`define VCS_STB_CYC 2'h2

// Host APB register offsets and fields
`define VCS_A_XFER 12'h000
`define VCS_A_STAT 12'h004
`define VCS_XF_SEL_BIT 8
`define VCS_XF_READ_BIT 9
`define VCS_ST_BUSY_BIT 0
`define VCS_ST_REFUSED_BIT 1

`endif

// ==== pkg/vcs_pkg.sv ====
// Types and decode functions for the voice channel setup link.
// Assumes vcs_defs.svh for numeric constants.
package vcs_pkg;

	// Coding type field of the seventh direct byte
	typedef enum logic [1:0] {
		vcs_adpcm4,
		vcs_second_adpcm_variant,
		vcs_pcm8_nonlinear,
		vcs_pcm8_straight
	} vcs_coding_e;

	// Host pin sequencer states
	typedef enum logic [2:0] {
		hs_idle,
		hs_setup,
		hs_strobe,
		hs_release,
		hs_gap
	} vcs_hstate_e;

	// Rate code to tenths of a kHz; zero marks an undefined code
	function automatic logic [8:0] vcs_rate_x10(input logic [3:0] code);
		case (code)
			4'h0: vcs_rate_x10 = 9'h028;
			4'h1: vcs_rate_x10 = 9'h050;
			4'h2: vcs_rate_x10 = 9'h0A0;
			4'h3: vcs_rate_x10 = 9'h140;
			4'h5: vcs_rate_x10 = 9'h040;
			4'h6: vcs_rate_x10 = 9'h080;
			4'h7: vcs_rate_x10 = 9'h100;
			4'h9: vcs_rate_x10 = 9'h035;
			4'hA: vcs_rate_x10 = 9'h06A;
			4'hB: vcs_rate_x10 = 9'h0D5;
			default: vcs_rate_x10 = 9'h000;
		endcase
	endfunction : vcs_rate_x10

endpackage : vcs_pkg

// ==== pkg/vcs_if.sv ====
// Parallel host port between the host controller and the voice device.
// Assumes both ends run on the same clock; the shared data bus level is resolved here.
`timescale 1ns/1ps
interface vcs_if;
	// Control strobes, all driven by the host
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic opsel;
	// Data bus halves and enables
	logic [7:0] h_data_o;
	logic h_data_oe;
	logic [7:0] d_data_o;
	logic d_data_oe;
	logic [7:0] data;

	// Host wins if both drive; an undriven bus reads as zero
	assign data = h_data_oe ? h_data_o : (d_data_oe ? d_data_o : 8'h00);

	modport dev (input cs_n, input wr_n, input rd_n, input opsel, input data, output d_data_o, output d_data_oe);
	modport host (output cs_n, output wr_n, output rd_n, output opsel, output h_data_o, output h_data_oe,
		input data);
endinterface : vcs_if

// ==== verilog/vcs_sil_timer.sv ====
// Silence timer for one channel: counts steps of a fixed cycle length.
// Assumes load is a one-cycle pulse and hold is a level from the same clock.
`timescale 1ns/1ps
`include "vcs_defs.svh"
module vcs_sil_timer #(
	parameter int STEP_CYC = `VCS_SIL_STEP_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic load,
	input wire logic [7:0] len,
	input wire logic hold,
	// Status
	output logic active,
	output logic done
);
	logic [23:0] tick_q; // Cycles within the current step
	logic [7:0] rem_q; // Steps still to run
	logic act_q; // Silence scheduled and not yet ended
	logic last_tick; // Final cycle of a step

	assign last_tick = (tick_q == 24'(STEP_CYC - 1));
	assign active = act_q;

	////////////////////////////////////////////////////////////////////////////////
	// Step counting; hold freezes it so silence waits for synthesis to end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_q <= 24'h000000;
			rem_q <= 8'h00;
			act_q <= 1'b0;
		end else if (load) begin
			tick_q <= 24'h000000;
			rem_q <= len;
			act_q <= (len != 8'h00);
		end else if (act_q && !hold) begin
			if (last_tick) begin
				tick_q <= 24'h000000;
				rem_q <= rem_q - 8'h01;
				if (rem_q == 8'h01) begin
					act_q <= 1'b0;
				end
			end else begin
				tick_q <= tick_q + 24'h000001;
			end
		end
	end

	// End pulse; a zero length ends at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
		end else begin
			done <= load ? (len == 8'h00) : (act_q && !hold && last_tick && rem_q == 8'h01);
		end
	end
endmodule : vcs_sil_timer

// ==== verilog/vcs_dev.sv ====
// Device end: staging register, per-channel setup commands and ready flags.
// Assumes host strobes come from logic on the same clock, so no pin synchronisers.
//
// Behaviour
// - Silence command schedules silence on selected channels
// - Silence length is staging value times 4.096ms
// - Silence sets start bit, drops ready flag
// - Silence waits until ongoing synthesis finishes
// - Silence ignored for channels not ready
// - Host writes length operand before command
// - Status read returns ready flags on data
// - Phrase command copies staging byte to channels
// - Phrase start requests table fetch first
// - Phrase number is eight bits wide
// - Direct command loads seven staged bytes
// - Direct playback skips management area fetch
// - Direct playback only on channels one-four
// - Seven operand strobes advance staging index
// - Operand select low resets staging index
// - Bytes carry begin then end address
// - Seventh byte holds rate and coding
// - Rate code decodes to listed frequencies
// - Coding field decodes to four playback types
// - Mask bit n selects channel n+1
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "vcs_defs.svh"
module vcs_dev #(
	parameter int SIL_STEP_CYC = `VCS_SIL_STEP_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Host port
	vcs_if.dev pins,
	// Synthesis engine status and start pulses
	input wire logic [7:0] synth_busy,
	input wire logic [7:0] chan_go,
	// Channel state
	output logic [7:0] start_q,
	output logic [7:0] ready_q,
	output logic [7:0] silence_q,
	output logic [7:0] fetch_req_q,
	// Phrase numbers, one byte per channel
	output logic [7:0][7:0] phrase_q,
	// Direct playback parameters, channels 1 to 4
	output logic [3:0] direct_sel_q,
	output logic [3:0][23:0] begin_address_q,
	output logic [3:0][23:0] end_address_q,
	output logic [3:0][3:0] rate_code_q,
	output vcs_pkg::vcs_coding_e [3:0] coding_type_q,
	output logic [3:0][8:0] rate_x10_q,
	output logic [3:0] rate_ok_q
);
	logic wr_prev_q; // Write strobe last cycle
	logic cs_prev_q; // Chip select last cycle
	logic opsel_prev_q; // Operand select last cycle
	logic [7:0] stage_q [0:6]; // Staging register bytes
	logic [2:0] idx_q; // Next staging byte
	logic [2:0] cnt_q; // Operand count of the finished entry
	logic strobe; // Write strobe rising edge while selected
	logic op_wr; // Operand byte arrives
	logic cmd_wr; // Command byte arrives
	logic [3:0] opcode; // Command code
	logic sel_ok; // Two operands staged: parameter and mask
	logic dir_ok; // Seven direct bytes staged
	logic [7:0] sil_go; // Silence accepted per channel
	logic [7:0] phr_wr; // Phrase number load per channel
	logic [3:0] dir_wr; // Direct load per channel
	logic [7:0] sil_done; // Silence ended per channel
	logic [7:0] start_d; // Next start register

	assign strobe = pins.wr_n && !wr_prev_q && !cs_prev_q;
	assign op_wr = strobe && pins.opsel;
	assign cmd_wr = strobe && !pins.opsel;
	assign opcode = pins.data[7:4];
	assign sel_ok = (cnt_q == `VCS_SEL_OPERANDS);
	assign dir_ok = (cnt_q == `VCS_DIRECT_BYTES);

	////////////////////////////////////////////////////////////////////////////////
	// Pin history for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_prev_q <= 1'b1;
			cs_prev_q <= 1'b1;
			opsel_prev_q <= 1'b0;
		end else begin
			wr_prev_q <= pins.wr_n;
			cs_prev_q <= pins.cs_n;
			opsel_prev_q <= pins.opsel;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Staging index; a drop of operand select ends the entry and rewinds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_q <= 3'h0;
			cnt_q <= 3'h0;
		end else if (cmd_wr) begin
			idx_q <= 3'h0;
			cnt_q <= 3'h0;
		end else if (opsel_prev_q && !pins.opsel) begin
			idx_q <= 3'h0;
			cnt_q <= idx_q;
		end else if (op_wr && idx_q != `VCS_DIRECT_BYTES) begin
			idx_q <= idx_q + 3'h1;
		end
	end

	// Staging bytes; extra bytes past the seventh are dropped
	always_ff @(posedge pclk) begin
		if (op_wr && idx_q != `VCS_DIRECT_BYTES) begin
			stage_q[idx_q] <= pins.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode per channel
	always_comb begin
		for (int ch = 0; ch < `VCS_NCH; ch++) begin
			// Silence only where the channel is ready
			sil_go[ch] = cmd_wr && opcode == `VCS_OP_SILENCE && sel_ok && stage_q[1][ch] && ready_q[ch];
			phr_wr[ch] = cmd_wr && opcode == `VCS_OP_PHRASE && sel_ok && stage_q[1][ch];
		end
		for (int ch = 0; ch < `VCS_DIRECT_CHANS; ch++) begin
			// Only four channels exist for direct loads; mask from the command nibble
			dir_wr[ch] = cmd_wr && opcode == `VCS_OP_DIRECT && dir_ok && pins.data[ch];
		end
		start_d = (start_q | sil_go) & ~sil_done;
	end

	// One silence timer per channel, held while synthesis runs
	for (genvar ch = 0; ch < `VCS_NCH; ch++) begin : g_sil
		vcs_sil_timer #(.STEP_CYC(SIL_STEP_CYC)) u_timer (
			.pclk(pclk),
			.presetn(presetn),
			.load(sil_go[ch]),
			.len(stage_q[0]),
			.hold(synth_busy[ch]),
			.active(),
			.done(sil_done[ch])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start register, silence flag and ready flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 8'h00;
			silence_q <= 8'h00;
			ready_q <= 8'hFF;
		end else begin
			start_q <= start_d;
			silence_q <= (silence_q | sil_go) & ~sil_done;
			ready_q <= ~(start_d | synth_busy);
		end
	end

	// Phrase numbers: a phrase load also returns the channel to table mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phrase_q <= '0;
			direct_sel_q <= 4'h0;
		end else begin
			for (int ch = 0; ch < `VCS_NCH; ch++) begin
				if (phr_wr[ch]) begin
					phrase_q[ch] <= stage_q[0];
				end
			end
			for (int ch = 0; ch < `VCS_DIRECT_CHANS; ch++) begin
				if (dir_wr[ch]) begin
					direct_sel_q[ch] <= 1'b1;
				end else if (phr_wr[ch]) begin
					direct_sel_q[ch] <= 1'b0;
				end
			end
		end
	end

	// Direct parameters, most significant byte first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			begin_address_q <= '0;
			end_address_q <= '0;
			rate_code_q <= '0;
			for (int ch = 0; ch < `VCS_DIRECT_CHANS; ch++) begin
				coding_type_q[ch] <= vcs_pkg::vcs_adpcm4;
			end
			rate_x10_q <= '0;
			rate_ok_q <= 4'h0;
		end else begin
			for (int ch = 0; ch < `VCS_DIRECT_CHANS; ch++) begin
				if (dir_wr[ch]) begin
					begin_address_q[ch] <= {stage_q[0], stage_q[1], stage_q[2]};
					end_address_q[ch] <= {stage_q[3], stage_q[4], stage_q[5]};
					rate_code_q[ch] <= stage_q[6][7:4];
					coding_type_q[ch] <= vcs_pkg::vcs_coding_e'(stage_q[6][3:2]);
					rate_x10_q[ch] <= vcs_pkg::vcs_rate_x10(stage_q[6][7:4]);
					rate_ok_q[ch] <= (vcs_pkg::vcs_rate_x10(stage_q[6][7:4]) != 9'h000);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Table fetch request on start, skipped for direct channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_req_q <= 8'h00;
		end else begin
			for (int ch = 0; ch < `VCS_NCH; ch++) begin
				fetch_req_q[ch] <= chan_go[ch] && !(ch < `VCS_DIRECT_CHANS && direct_sel_q[ch[1:0]]);
			end
		end
	end

	// Status read: ready flags on the bus while selected and read low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins.d_data_o <= 8'h00;
			pins.d_data_oe <= 1'b0;
		end else begin
			pins.d_data_o <= ready_q;
			pins.d_data_oe <= !pins.cs_n && !pins.rd_n;
		end
	end
endmodule : vcs_dev

// ==== verilog/vcs_host.sv ====
// Host end: APB slave that turns register writes into pin strobes.
// Assumes one clock shared with the device and an APB master on the user side.
`timescale 1ns/1ps
`include "vcs_defs.svh"
module vcs_host (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	// Host port
	vcs_if.host pins
);
	vcs_pkg::vcs_hstate_e st_q; // Pin sequencer state
	logic [1:0] stb_cnt_q; // Strobe low cycles
	logic is_read_q; // Current pin transfer is a read
	logic chk_q; // Read is a ready check before silence
	logic [7:0] byte_q; // Command byte held during a check
	logic [7:0] mask_q; // Last operand, used as channel mask
	logic [2:0] op_cnt_q; // Operands since last command
	logic [7:0] rd_byte_q; // Last status byte read
	logic refused_q; // Sticky: silence dropped, channel busy
	logic acc; // APB access completes
	logic xfer_wr; // Accepted transfer write
	logic busy; // Pin sequencer in use
	logic ok_chk; // All masked channels ready

	assign acc = psel && penable && pready_q;
	assign busy = (st_q != vcs_pkg::hs_idle);
	// Refusal is decided at setup; a refused access must never start the sequencer
	assign xfer_wr = acc && pwrite && paddr == `VCS_A_XFER && !busy && !pslverr_q;
	assign ok_chk = ((rd_byte_q & mask_q) == mask_q);

	////////////////////////////////////////////////////////////////////////////////
	// APB handshake: one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && (paddr != `VCS_A_XFER && paddr != `VCS_A_STAT ||
				pwrite && paddr == `VCS_A_XFER && busy);
			prdata_q <= (paddr == `VCS_A_STAT) ? {16'h0000, rd_byte_q, 6'h00, refused_q, busy} : 32'h00000000;
		end
	end

	// Refused flag: a new refusal wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused_q <= 1'b0;
		end else if (st_q == vcs_pkg::hs_gap && chk_q && !ok_chk) begin
			refused_q <= 1'b1;
		end else if (acc && pwrite && paddr == `VCS_A_STAT && pwdata[`VCS_ST_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand tracking; the seventh direct byte gets its low bits cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 8'h00;
			op_cnt_q <= 3'h0;
		end else if (xfer_wr && !pwdata[`VCS_XF_READ_BIT]) begin
			if (pwdata[`VCS_XF_SEL_BIT]) begin
				mask_q <= pwdata[7:0];
				op_cnt_q <= (op_cnt_q == `VCS_DIRECT_BYTES) ? op_cnt_q : op_cnt_q + 3'h1;
			end else begin
				op_cnt_q <= 3'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin sequencer: setup, strobe, release, gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= vcs_pkg::hs_idle;
			stb_cnt_q <= 2'h0;
			is_read_q <= 1'b0;
			chk_q <= 1'b0;
			byte_q <= 8'h00;
			rd_byte_q <= 8'h00;
			pins.cs_n <= 1'b1;
			pins.wr_n <= 1'b1;
			pins.rd_n <= 1'b1;
			pins.opsel <= 1'b0;
			pins.h_data_o <= 8'h00;
			pins.h_data_oe <= 1'b0;
		end else begin
			case (st_q)
				vcs_pkg::hs_idle: begin
					if (xfer_wr) begin
						// Silence commands check the ready flags first
						chk_q <= !pwdata[`VCS_XF_SEL_BIT] && pwdata[7:4] == `VCS_OP_SILENCE;
						is_read_q <= pwdata[`VCS_XF_READ_BIT] ||
							(!pwdata[`VCS_XF_SEL_BIT] && pwdata[7:4] == `VCS_OP_SILENCE);
						byte_q <= (pwdata[`VCS_XF_SEL_BIT] && op_cnt_q == 3'h6) ? {pwdata[7:2], 2'b00} : pwdata[7:0];
						if (!pwdata[`VCS_XF_READ_BIT]) begin
							pins.opsel <= pwdata[`VCS_XF_SEL_BIT];
						end
						st_q <= vcs_pkg::hs_setup;
					end
				end
				vcs_pkg::hs_setup: begin
					pins.cs_n <= 1'b0;
					pins.h_data_o <= byte_q;
					pins.h_data_oe <= !is_read_q;
					st_q <= vcs_pkg::hs_strobe;
					stb_cnt_q <= 2'h0;
					pins.wr_n <= is_read_q;
					pins.rd_n <= !is_read_q;
				end
				vcs_pkg::hs_strobe: begin
					stb_cnt_q <= stb_cnt_q + 2'h1;
					if (stb_cnt_q == `VCS_STB_CYC - 2'h1) begin
						if (is_read_q) begin
							rd_byte_q <= pins.data;
						end
						pins.wr_n <= 1'b1;
						pins.rd_n <= 1'b1;
						st_q <= vcs_pkg::hs_release;
					end
				end
				vcs_pkg::hs_release: begin
					pins.cs_n <= 1'b1;
					pins.h_data_oe <= 1'b0;
					st_q <= vcs_pkg::hs_gap;
				end
				vcs_pkg::hs_gap: begin
					// After a good check, send the command itself
					if (chk_q && ok_chk) begin
						chk_q <= 1'b0;
						is_read_q <= 1'b0;
						pins.opsel <= 1'b0;
						st_q <= vcs_pkg::hs_setup;
					end else begin
						chk_q <= 1'b0;
						st_q <= vcs_pkg::hs_idle;
					end
				end
				default: begin
					st_q <= vcs_pkg::hs_idle;
				end
			endcase
		end
	end
endmodule : vcs_host

// ==== testbench/vcs_link_asserts.sv ====
// Checker for the host pin link and the device's channel flags.
// Assumes one clock; instantiated beside the link, fed plain signals.
`timescale 1ns/1ps
module vcs_link_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link pins
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic opsel,
	input wire logic h_data_oe,
	input wire logic d_data_oe,
	input wire logic [7:0] d_data_o,
	// Device channel state
	input wire logic [7:0] ready_q,
	input wire logic [7:0] start_q,
	input wire logic [7:0] silence_q,
	input wire logic [7:0] synth_busy
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	//////////////////////////////
	// Status byte mirrors the ready flags
	a_status_mirrors_ready: assert property (d_data_oe && $stable(ready_q) |-> d_data_o == ready_q)
		else $error("status byte differs from ready flags");
	// Device drives only after a read select
	a_oe_needs_read: assert property (d_data_oe |-> $past(cs_n) == 1'b0 && $past(rd_n) == 1'b0)
		else $error("device drove bus without read");
	a_no_bus_clash: assert property (!(h_data_oe && d_data_oe))
		else $error("both ends drive the bus");
	// Strobe is two cycles inside chip select
	a_strobe_width: assert property ($fell(wr_n) |-> (!cs_n && !wr_n) [*2] ##1 wr_n)
		else $error("write strobe width wrong");
	a_write_drives_bus: assert property (!wr_n |-> h_data_oe)
		else $error("strobe without data");
	a_opsel_steady: assert property (!cs_n |-> $stable(opsel))
		else $error("operand select moved in a strobe");
	a_release_order: assert property ($rose(cs_n) |-> $past(wr_n) && $past(rd_n))
		else $error("select released before strobe");
	// Silence marks the channel started and not ready
	a_silence_drops_ready: assert property ($rose(silence_q[0]) |-> start_q[0] ##[0:1] !ready_q[0])
		else $error("silence left channel ready");
	a_silent_not_ready: assert property (silence_q[0] && $past(silence_q[0]) |-> !ready_q[0])
		else $error("ready during silence");
	// Timer is frozen while the channel synthesizes
	a_busy_holds_silence: assert property (silence_q[2] && synth_busy[2] |=> silence_q[2])
		else $error("silence ended during synthesis");
	c_write: cover property ($fell(wr_n) && opsel);
	c_read: cover property ($rose(d_data_oe));
	c_silence: cover property ($rose(silence_q[0]));
	c_frozen: cover property (silence_q[2] && synth_busy[2]);
endmodule : vcs_link_asserts

// ==== testbench/voice_channel_setup_commands_test.sv ====
// Top bench: APB master on the host end, engine stubs on the device end.
// Assumes the host end is the only driver of the link.
`timescale 1ns/1ps
`include "vcs_defs.svh"
module voice_channel_setup_commands_test;
	localparam int STEP = 4; // Short silence step keeps the run brief
	// Rate codes in tenths of a kHz, zero where undefined
	localparam logic [8:0] RT [16] = '{9'h028, 9'h050, 9'h0A0, 9'h140, 9'h000, 9'h040, 9'h080, 9'h100,
		9'h000, 9'h035, 9'h06A, 9'h0D5, 9'h000, 9'h000, 9'h000, 9'h000};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	// APB side
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata_q, rdv;
	logic pready_q, pslverr_q, err;
	// Engine side and device outputs
	logic [7:0] synth_busy = 8'h00, chan_go = 8'h00, fetch_seen = 8'h00;
	logic [7:0] start_q, ready_q, silence_q, fetch_req_q;
	logic [7:0][7:0] phrase_q, exp_ph;
	logic [3:0] direct_sel_q, rate_ok_q;
	logic [3:0][23:0] begin_address_q, end_address_q;
	logic [3:0][3:0] rate_code_q;
	vcs_pkg::vcs_coding_e [3:0] coding_type_q;
	logic [3:0][8:0] rate_x10_q;
	logic [31:0] seed = 32'h5F904521;
	int n_fail = 0, samples_checked = 0, sil_cyc = 0;

	vcs_if link ();
	vcs_host vcs_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .pins(link));
	vcs_dev #(.SIL_STEP_CYC(STEP)) vcs_dev_inst (.pclk(pclk), .presetn(presetn), .pins(link),
		.synth_busy(synth_busy), .chan_go(chan_go), .start_q(start_q), .ready_q(ready_q), .silence_q(silence_q),
		.fetch_req_q(fetch_req_q), .phrase_q(phrase_q), .direct_sel_q(direct_sel_q),
		.begin_address_q(begin_address_q), .end_address_q(end_address_q), .rate_code_q(rate_code_q),
		.coding_type_q(coding_type_q), .rate_x10_q(rate_x10_q), .rate_ok_q(rate_ok_q));
	vcs_link_asserts vcs_link_asserts_inst (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n), .wr_n(link.wr_n),
		.rd_n(link.rd_n), .opsel(link.opsel), .h_data_oe(link.h_data_oe), .d_data_oe(link.d_data_oe),
		.d_data_o(link.d_data_o), .ready_q(ready_q), .start_q(start_q), .silence_q(silence_q),
		.synth_busy(synth_busy));

	initial begin
		forever #25 pclk = ~pclk;
	end
	// Count running silence cycles on channel one and collect fetch pulses
	always @(posedge pclk) begin
		if (silence_q[0] === 1'b1 && synth_busy[0] === 1'b0) begin
			sil_cyc <= sil_cyc + 1;
		end
		fetch_seen <= fetch_seen | fetch_req_q;
	end
	//////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; an idle cycle follows so strobes never double up
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer however long it takes; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready_q !== 1'b1);
		rdv = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// Poll until the pin sequencer is free
	task automatic idle();
		do begin
			apb(1'b0, `VCS_A_STAT, 32'h0);
		end while (rdv[0] !== 1'b0);
	endtask : idle
	task automatic put(input logic [9:0] v);
		apb(1'b1, `VCS_A_XFER, {22'h0, v});
		idle();
	endtask : put
	task automatic waitr(input logic [7:0] m);
		for (int k = 0; k < 2000; k++) begin
			@(posedge pclk);
			if ((ready_q & m) === m) break;
		end
	endtask : waitr
	task automatic finish_test();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	//////////////////////////////
	initial begin
		repeat (40000) @(posedge pclk);
		n_fail++;
		finish_test();
	end
	initial begin
		int i, j, n, L;
		logic [7:0] p, m, b7;
		logic [3:0] dm;
		logic [23:0] ba, ea;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk(ready_q, 8'hFF);
		chk(start_q, 8'h00);
		// Unmapped place and a transfer while busy are refused
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rdv, 32'h0);
		apb(1'b1, `VCS_A_XFER, 32'h200);
		apb(1'b1, `VCS_A_XFER, 32'h200);
		chk(err, 1'b1);
		idle();
		put(10'h200);
		chk(rdv[15:8], 8'hFF);
		// Phrase numbers, full mask first
		exp_ph = 64'h0;
		for (i = 0; i < 4; i++) begin
			p = rnd();
			m = (i == 0) ? 8'hFF : rnd();
			put({2'b01, p});
			put({2'b01, m});
			put({2'b00, `VCS_OP_PHRASE, 4'h0});
			for (j = 0; j < 8; j++) begin
				if (m[j]) exp_ph[j] = p;
				chk(phrase_q[j], exp_ph[j]);
			end
		end
		// Direct loads over rate codes 0 to 11; an aborted entry before the second load
		for (i = 0; i < 12; i++) begin
			ba = rnd();
			ea = rnd();
			b7 = {i[3:0], 4'(rnd() & 32'hC)};
			dm = (i == 0) ? 4'hF : (rnd() | 4'h1);
			if (i == 1) begin
				for (j = 0; j < 3; j++) put({2'b01, ~ba[7:0]});
				put({2'b00, `VCS_OP_DIRECT, dm});
			end
			for (j = 0; j < 3; j++) put({2'b01, ba[23 - 8 * j -: 8]});
			for (j = 0; j < 3; j++) put({2'b01, ea[23 - 8 * j -: 8]});
			put({2'b01, b7});
			put({2'b00, `VCS_OP_DIRECT, dm});
			for (j = 0; j < 4; j++) begin
				if (dm[j]) begin
					chk({direct_sel_q[j], begin_address_q[j], end_address_q[j]}, {1'b1, ba, ea});
					chk({rate_code_q[j], 2'(coding_type_q[j])}, {i[3:0], b7[3:2]});
					chk({rate_ok_q[j], rate_x10_q[j]}, {RT[i] != 9'h000, RT[i]});
				end
			end
		end
		// Silence on channels one and three, channel three held by synthesis
		L = 20 + (rnd() & 7);
		n = sil_cyc;
		put({2'b01, L[7:0]});
		put(10'h105);
		put({2'b00, `VCS_OP_SILENCE, 4'h0});
		synth_busy <= 8'h04;
		chk({start_q[2], start_q[0], ready_q[2], ready_q[0]}, 4'hC);
		put(10'h101);
		put(10'h101);
		put({2'b00, `VCS_OP_SILENCE, 4'h0});
		apb(1'b0, `VCS_A_STAT, 32'h0);
		chk(rdv[1], 1'b1);
		apb(1'b1, `VCS_A_STAT, 32'h2);
		waitr(8'h01);
		n = sil_cyc - n - L * STEP;
		chk(n >= 0 && n <= 2, 1'b1);
		chk(silence_q[2], 1'b1);
		synth_busy <= 8'h00;
		waitr(8'hFF);
		chk(ready_q, 8'hFF);
		// Phrase channel fetches on start, direct channel does not
		put(10'h17E);
		put(10'h102);
		put({2'b00, `VCS_OP_PHRASE, 4'h0});
		chk(direct_sel_q[1:0], 2'b01);
		chan_go <= 8'h03;
		@(posedge pclk);
		chan_go <= 8'h00;
		repeat (6) @(posedge pclk);
		chk(fetch_seen[1:0], 2'b10);
		finish_test();
	end
endmodule : voice_channel_setup_commands_test
